// File: src/spb_pkg.sv
package spb_pkg;
  // ==========================================================
  // Register offsets (byte addresses on the register port).
  localparam logic [7:0] OFS_CONTROL_ONE = 8'h00;
  localparam logic [7:0] OFS_CONTROL_TWO = 8'h04;
  localparam logic [7:0] OFS_BIT_RATE    = 8'h08;
  localparam logic [7:0] OFS_FLAGS       = 8'h0c;
  localparam logic [7:0] OFS_DATA_PORT   = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h18;

  // ==========================================================
  // Field positions.
  localparam int BIT_RX_IRQ_EN   = 7;
  localparam int BIT_ENABLE      = 6;
  localparam int BIT_TX_IRQ_EN   = 5;
  localparam int BIT_MASTER      = 4;
  localparam int BIT_SEL_OUT_EN  = 1;
  localparam int BIT_FAULT_EN    = 4;
  localparam int BIT_RX_FULL     = 7;
  localparam int BIT_TX_EMPTY    = 5;
  localparam int BIT_MODE_FAULT  = 4;
  localparam int PRESCALE_LSB    = 4;
  localparam int RATE_LSB        = 0;
  localparam int EVT_RX_DONE     = 0;
  localparam int EVT_TX_EMPTY    = 1;
  localparam int EVT_FAULT       = 2;

  // ==========================================================
  // Reset values and counts.
  localparam logic [7:0] RST_CONTROL_ONE = 8'h00;
  localparam logic [7:0] RST_CONTROL_TWO = 8'h00;
  localparam logic [7:0] RST_BIT_RATE    = 8'h00;
  localparam logic [2:0] RST_EVENTS      = 3'h0;
  localparam logic [3:0] LAST_HALF_BIT   = 4'hf;

  // ==========================================================
  // Control register one, decoded.
  typedef struct packed {
    logic rx_irq_enable;
    logic module_enable;
    logic transmit_irq_enable;
    logic master_select;
    logic select_output_enable;
  } spb_ctl_t;

  typedef enum logic [0:0] {
    SPB_IDLE  = 1'b0,
    SPB_SHIFT = 1'b1
  } spb_state_t;
endpackage

// File: src/spb_top.sv
`timescale 1ns/1ps
module spb_top (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_miso,
  input  wire logic       i_ss_n,
  output logic            o_sclk,
  output logic            o_mosi,
  output logic            o_tx_irq,
  output logic            o_rx_irq,
  output logic            o_irq
);
  // ==========================================================
  // Register port decode.
  logic wr_ctl1, wr_ctl2, wr_rate, wr_data, wr_stat, wr_mask;
  logic rd_flags, rd_data;
  assign wr_ctl1  = i_wr && (i_addr == spb_pkg::OFS_CONTROL_ONE);
  assign wr_ctl2  = i_wr && (i_addr == spb_pkg::OFS_CONTROL_TWO);
  assign wr_rate  = i_wr && (i_addr == spb_pkg::OFS_BIT_RATE);
  assign wr_data  = i_wr && (i_addr == spb_pkg::OFS_DATA_PORT);
  assign wr_stat  = i_wr && (i_addr == spb_pkg::OFS_IRQ_STATUS);
  assign wr_mask  = i_wr && (i_addr == spb_pkg::OFS_IRQ_MASK);
  assign rd_flags = i_rd && (i_addr == spb_pkg::OFS_FLAGS);
  assign rd_data  = i_rd && (i_addr == spb_pkg::OFS_DATA_PORT);

  // ==========================================================
  // Configuration registers.
  logic [7:0]         ctl1_q;
  logic [7:0]         ctl2_q;
  logic [7:0]         rate_q;
  spb_pkg::spb_ctl_t  ctl;
  logic [2:0]         prescale_select;
  logic [2:0]         rate_divider_select;
  logic               fault_detect_enable;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctl1_q <= spb_pkg::RST_CONTROL_ONE;
      ctl2_q <= spb_pkg::RST_CONTROL_TWO;
      rate_q <= spb_pkg::RST_BIT_RATE;
    end else begin
      if (wr_ctl1) begin
        ctl1_q <= i_wdata;
      end
      if (wr_ctl2) begin
        ctl2_q <= i_wdata;
      end
      // No dependence on enable or transfer activity.
      if (wr_rate) begin
        rate_q <= i_wdata & 8'h77;
      end
    end
  end

  assign ctl.rx_irq_enable        = ctl1_q[spb_pkg::BIT_RX_IRQ_EN];
  assign ctl.module_enable        = ctl1_q[spb_pkg::BIT_ENABLE];
  assign ctl.transmit_irq_enable  = ctl1_q[spb_pkg::BIT_TX_IRQ_EN];
  assign ctl.master_select        = ctl1_q[spb_pkg::BIT_MASTER];
  assign ctl.select_output_enable = ctl1_q[spb_pkg::BIT_SEL_OUT_EN];
  assign fault_detect_enable      = ctl2_q[spb_pkg::BIT_FAULT_EN];
  assign prescale_select          = rate_q[spb_pkg::PRESCALE_LSB +: 3];
  assign rate_divider_select      = rate_q[spb_pkg::RATE_LSB +: 3];

  // ==========================================================
  // Pin synchronisers.
  logic [1:0] miso_sync_q;
  logic [1:0] ss_sync_q;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      miso_sync_q <= 2'h0;
      ss_sync_q   <= 2'h3;
    end else begin
      miso_sync_q <= {miso_sync_q[0], i_miso};
      ss_sync_q   <= {ss_sync_q[0], i_ss_n};
    end
  end

  // ==========================================================
  // Bit-rate generator.
  // The prescaler ticks once per (code+1) bus cycles; the divider toggles
  // the serial clock every 2^code ticks, so a half period is the product.
  spb_pkg::spb_state_t state_q;
  logic [2:0] pre_cnt_q;
  logic [7:0] div_cnt_q;
  logic       pre_tick;
  logic       half_tick;
  logic [7:0] div_last;

  assign pre_tick  = (pre_cnt_q == prescale_select);
  assign div_last  = 8'((9'h001 << rate_divider_select) - 9'h001);
  assign half_tick = pre_tick && (div_cnt_q == div_last);

  always_ff @(posedge i_clk) begin
    if (i_reset || state_q != spb_pkg::SPB_SHIFT) begin
      pre_cnt_q <= 3'h0;
      div_cnt_q <= 8'h00;
    end else if (pre_tick) begin
      pre_cnt_q <= 3'h0;
      div_cnt_q <= half_tick ? 8'h00 : div_cnt_q + 8'h01;
    end else begin
      pre_cnt_q <= pre_cnt_q + 3'h1;
    end
  end

  // ==========================================================
  // Master shifter and buffers.
  // Only the master side is shifted here; the receive path samples on the
  // leading edge and the transmit path changes on the trailing edge.
  logic [7:0] tx_buf_q;
  logic       tx_full_q;
  logic [7:0] shift_q;
  logic [3:0] half_q;
  logic       rx_bit_q;
  logic [7:0] rx_buf_q;
  logic       rx_full_q;
  logic       tx_empty_q;
  logic       fault_q;
  logic       arm_rx_q, arm_tx_q, arm_fault_q;
  logic       accept_wr;
  logic       xfer_done;
  logic       load_shift;
  logic       fault_in;
  logic       enabled;

  assign enabled    = ctl.module_enable;
  assign accept_wr  = wr_data && arm_tx_q;
  assign xfer_done  = (state_q == spb_pkg::SPB_SHIFT) && half_tick &&
                      (half_q == spb_pkg::LAST_HALF_BIT);
  assign load_shift = enabled && ctl.master_select && tx_full_q &&
                      ((state_q == spb_pkg::SPB_IDLE) || xfer_done);

  always_ff @(posedge i_clk) begin
    if (i_reset || !enabled) begin
      state_q <= spb_pkg::SPB_IDLE;
      half_q  <= 4'h0;
      shift_q <= 8'h00;
      rx_bit_q <= 1'b0;
      o_sclk  <= 1'b0;
    end else if (load_shift) begin
      state_q <= spb_pkg::SPB_SHIFT;
      half_q  <= 4'h0;
      shift_q <= tx_buf_q;
      o_sclk  <= 1'b0;
    end else if (xfer_done) begin
      state_q <= spb_pkg::SPB_IDLE;
      o_sclk  <= 1'b0;
    end else if (state_q == spb_pkg::SPB_SHIFT && half_tick) begin
      half_q <= half_q + 4'h1;
      o_sclk <= ~o_sclk;
      if (o_sclk) begin
        shift_q <= {shift_q[6:0], rx_bit_q};
      end else begin
        rx_bit_q <= miso_sync_q[1];
      end
    end
  end

  // The leading edge samples into a holding bit, so the outgoing bit 0 is
  // not overwritten before it is sent; the trailing edge shifts it in.
  logic [7:0] rx_word;
  assign rx_word = {shift_q[6:0], rx_bit_q};

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_mosi <= 1'b0;
    end else begin
      o_mosi <= shift_q[7];
    end
  end

  // ==========================================================
  // Transmit buffer and transmit-empty flag.
  always_ff @(posedge i_clk) begin
    if (i_reset || !enabled) begin
      tx_full_q  <= 1'b0;
      tx_buf_q   <= 8'h00;
      tx_empty_q <= 1'b1;
    end else begin
      if (accept_wr) begin
        tx_buf_q   <= i_wdata;
        tx_full_q  <= 1'b1;
        tx_empty_q <= 1'b0;
      end else if (load_shift) begin
        tx_full_q  <= 1'b0;
        tx_empty_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Receive buffer and receive-full flag.
  always_ff @(posedge i_clk) begin
    if (i_reset || !enabled) begin
      rx_full_q <= 1'b0;
      rx_buf_q  <= 8'h00;
    end else if (xfer_done && !rx_full_q) begin
      rx_full_q <= 1'b1;
      rx_buf_q  <= rx_word;
    end else if (xfer_done) begin
      rx_full_q <= 1'b1;
    end else if (rd_data && arm_rx_q) begin
      rx_full_q <= 1'b0;
    end
  end

  // ==========================================================
  // Mode-fault detection.
  // A low select input is a level, so the flag re-sets while it stays low.
  assign fault_in = enabled && ctl.master_select && fault_detect_enable &&
                    !ctl.select_output_enable && !ss_sync_q[1];

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      fault_q <= 1'b0;
    end else if (fault_in) begin
      fault_q <= 1'b1;
    end else if (wr_ctl1 && arm_fault_q) begin
      fault_q <= 1'b0;
    end
  end

  // ==========================================================
  // Clearing sequence arming: a status read that sees the flag set.
  always_ff @(posedge i_clk) begin
    if (i_reset || !enabled) begin
      arm_rx_q <= 1'b0;
      arm_tx_q <= 1'b0;
    end else begin
      if (rd_flags) begin
        arm_rx_q <= rx_full_q;
      end else if (rd_data) begin
        arm_rx_q <= 1'b0;
      end
      if (rd_flags) begin
        arm_tx_q <= tx_empty_q;
      end else if (wr_data) begin
        arm_tx_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      arm_fault_q <= 1'b0;
    end else if (rd_flags) begin
      arm_fault_q <= fault_q;
    end else if (wr_ctl1) begin
      arm_fault_q <= 1'b0;
    end
  end

  // ==========================================================
  // Sticky event status and mask.
  logic [2:0] evt_q;
  logic [2:0] mask_q;
  logic [2:0] evt_set;
  logic       tx_empty_d1_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tx_empty_d1_q <= 1'b1;
    end else begin
      tx_empty_d1_q <= tx_empty_q;
    end
  end

  assign evt_set[spb_pkg::EVT_RX_DONE]  = xfer_done;
  assign evt_set[spb_pkg::EVT_TX_EMPTY] = tx_empty_q && !tx_empty_d1_q;
  assign evt_set[spb_pkg::EVT_FAULT]    = fault_in && !fault_q;

  // A set in the same cycle as a write-one clear wins, so no event is lost.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      evt_q  <= spb_pkg::RST_EVENTS;
      mask_q <= spb_pkg::RST_EVENTS;
    end else begin
      evt_q <= (evt_q & ~(wr_stat ? i_wdata[2:0] : 3'h0)) | evt_set;
      if (wr_mask) begin
        mask_q <= i_wdata[2:0];
      end
    end
  end

  assign o_tx_irq = tx_empty_q && ctl.transmit_irq_enable;
  assign o_rx_irq = (rx_full_q || fault_q) && ctl.rx_irq_enable;
  assign o_irq    = |(evt_q & mask_q);

  // ==========================================================
  // Read data, one cycle after the strobe; unmapped addresses read zero.
  logic [7:0] flags;
  assign flags = {rx_full_q, 1'b0, tx_empty_q, fault_q, 4'h0};

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (!i_rd) begin
      o_rdata <= 8'h00;
    end else begin
      unique case (i_addr)
        spb_pkg::OFS_CONTROL_ONE: o_rdata <= ctl1_q;
        spb_pkg::OFS_CONTROL_TWO: o_rdata <= ctl2_q;
        spb_pkg::OFS_BIT_RATE:    o_rdata <= rate_q;
        spb_pkg::OFS_FLAGS:       o_rdata <= flags;
        spb_pkg::OFS_DATA_PORT:   o_rdata <= rx_buf_q;
        spb_pkg::OFS_IRQ_STATUS:  o_rdata <= {5'h00, evt_q};
        spb_pkg::OFS_IRQ_MASK:    o_rdata <= {5'h00, mask_q};
        default:                  o_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// File: test/spb_props.sv
`timescale 1ns/1ps
module spb_props (
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_miso,
  input wire logic       i_ss_n,
  input wire logic       o_sclk,
  input wire logic       o_mosi,
  input wire logic       o_tx_irq,
  input wire logic       o_rx_irq,
  input wire logic       o_irq
);
  // ==========================================================
  // Shadow settings and serial clock phase counters.
  logic [7:0]  ctl_q;
  logic [7:0]  br_q;
  logic [10:0] hi_q;
  logic [10:0] lo_q;
  logic [10:0] half;
  assign half = (11'(br_q[6:4]) + 11'h001) << br_q[2:0];
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctl_q <= 8'h00;
      br_q  <= 8'h00;
    end else if (i_wr && i_addr == spb_pkg::OFS_CONTROL_ONE) begin
      ctl_q <= i_wdata;
    end else if (i_wr && i_addr == spb_pkg::OFS_BIT_RATE) begin
      br_q <= i_wdata;
    end
  end
  // The low count saturates so that a long idle never wraps into a short phase.
  always_ff @(posedge i_clk) begin
    hi_q <= o_sclk ? hi_q + 11'h001 : 11'h000;
    lo_q <= (o_sclk || i_reset) ? 11'h000 : lo_q + {10'h000, lo_q != 11'h7ff};
  end
  // ==========================================================
  // Assertions.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  flags_zero_a: assert property ($past(i_rd) && $past(i_addr) == spb_pkg::OFS_FLAGS |->
    (o_rdata & 8'h4f) == 8'h00) else $error("unused flag bits nonzero");
  rate_read_a: assert property ($past(i_rd) && $past(i_addr) == spb_pkg::OFS_BIT_RATE |->
    o_rdata == (br_q & 8'h77)) else $error("bit rate readback wrong");
  dis_empty_a: assert property ((ctl_q[5] && !ctl_q[6]) [*3] |-> o_tx_irq)
    else $error("disabled unit not empty");
  sclk_quiet_a: assert property ((!ctl_q[6] || !ctl_q[4]) [*3] |-> !o_sclk)
    else $error("serial clock runs while stopped");
  high_len_a: assert property ($fell(o_sclk) |-> hi_q == half)
    else $error("serial clock high phase wrong");
  low_len_a: assert property ($rose(o_sclk) |-> lo_q >= half)
    else $error("serial clock low phase short");
  tx_irq_gate_a: assert property (!ctl_q[5] |-> !o_tx_irq)
    else $error("transmit request while disabled");
  rx_irq_gate_a: assert property (!ctl_q[7] |-> !o_rx_irq)
    else $error("receive request while disabled");
  cover property ($fell(o_sclk));
  cover property (o_tx_irq);
  cover property (o_rx_irq);
endmodule
bind spb_top spb_props u_spb_props (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_miso, .i_ss_n, .o_sclk, .o_mosi, .o_tx_irq, .o_rx_irq, .o_irq);

// File: test/spb_slave.sv
`timescale 1ns/1ps
module spb_slave (
  input  wire logic       i_sclk,
  input  wire logic       i_mosi,
  input  wire logic [7:0] i_reply,
  output logic            o_miso,
  output logic [7:0]      o_got,
  output int              o_frames
);
  // ==========================================================
  // Clock format zero: sample on the rise, next bit after each fall.
  logic [2:0] rise_q = 3'h0;
  logic [2:0] fall_q = 3'h0;
  initial o_frames = 0;
  assign o_miso = i_reply[3'h7 - fall_q];
  always @(posedge i_sclk) begin
    o_got  <= {o_got[6:0], i_mosi};
    rise_q <= rise_q + 3'h1;
    if (rise_q == 3'h7) o_frames <= o_frames + 1;
  end
  // A fall with no rise before it is the clock leaving unknown at reset.
  always @(negedge i_sclk) if (fall_q != rise_q) fall_q <= fall_q + 3'h1;
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
  logic       i_clk   = 1'b0;
  logic       i_reset = 1'b1;
  logic [7:0] i_addr  = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr    = 1'b0;
  logic       i_rd    = 1'b0;
  logic       i_ss_n  = 1'b1;
  logic [7:0] reply   = 8'h00;
  logic [7:0] o_rdata, got, d, b, e;
  logic       i_miso, o_sclk, o_mosi, o_tx_irq, o_rx_irq, o_irq, f;
  logic [2:0] kk;
  logic [7:0] corner [3] = '{8'h07, 8'h70, 8'h11};
  int         errors  = 0;
  int         n_tests = 0;
  int         cyc     = 0;
  int         nf      = 0;
  int         frames;
  always #4 i_clk = ~i_clk;
  spb_top u_spb_top (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_miso, .i_ss_n,
    .o_sclk, .o_mosi, .o_tx_irq, .o_rx_irq, .o_irq);
  spb_slave u_spb_slave (.i_sclk(o_sclk), .i_mosi(o_mosi), .i_reply(reply), .o_miso(i_miso),
    .o_got(got), .o_frames(frames));
  // ==========================================================
  // Tasks.
  task automatic conclude;
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    n_tests++;
    if (g !== x) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    v = o_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] x);
    rd(a, d);
    chk(d, x);
  endtask
  // Waits for the next byte to finish, then lets the flags settle.
  task automatic frame;
    nf++;
    for (int k = 0; k < 5000 && !(frames >= nf && !o_sclk); k++) @(posedge i_clk);
    repeat (4) @(posedge i_clk);
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("[ERR] %0t run took too long", $time);
      conclude();
    end
  end
  // ==========================================================
  // Main sequence.
  initial begin
    b = 8'($urandom(37));
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    rdc(spb_pkg::OFS_FLAGS, 8'h20);
    wr(spb_pkg::OFS_FLAGS, 8'hff);
    rdc(spb_pkg::OFS_FLAGS, 8'h20);
    rdc(8'hfc, 8'h00);
    for (int k = 0; k < 6; k++) begin
      b = 8'($urandom);
      wr(spb_pkg::OFS_BIT_RATE, b);
      rdc(spb_pkg::OFS_BIT_RATE, b & 8'h77);
    end
    wr(spb_pkg::OFS_CONTROL_ONE, 8'h70);
    rd(spb_pkg::OFS_DATA_PORT, d);
    wr(spb_pkg::OFS_DATA_PORT, 8'h5a);
    rdc(spb_pkg::OFS_FLAGS, 8'h20);
    chk({7'h00, o_tx_irq}, 8'h01);
    chk(8'(frames), 8'h00);
    // Half periods stay at four cycles or more so the synced input settles.
    for (int k = 0; k < 6; k++) begin
      b = (k < 3) ? corner[k] : {1'b0, 3'($urandom_range(3, 1)), 1'b0, 3'($urandom_range(3, 1))};
      wr(spb_pkg::OFS_BIT_RATE, b);
      b = 8'($urandom);
      reply = 8'($urandom);
      rdc(spb_pkg::OFS_FLAGS, 8'h20);
      wr(spb_pkg::OFS_DATA_PORT, b);
      frame();
      chk(got, b);
      rd(spb_pkg::OFS_DATA_PORT, d);
      chk(d, reply);
      rdc(spb_pkg::OFS_FLAGS, 8'ha0);
      rdc(spb_pkg::OFS_DATA_PORT, reply);
      rdc(spb_pkg::OFS_FLAGS, 8'h20);
    end
    wr(spb_pkg::OFS_BIT_RATE, 8'h13);
    b = 8'($urandom);
    reply = 8'($urandom);
    e = reply;
    rdc(spb_pkg::OFS_FLAGS, 8'h20);
    wr(spb_pkg::OFS_DATA_PORT, b);
    rdc(spb_pkg::OFS_FLAGS, 8'h20);
    wr(spb_pkg::OFS_DATA_PORT, ~b);
    rdc(spb_pkg::OFS_FLAGS, 8'h00);
    frame();
    reply = ~e;
    chk(got, b);
    frame();
    chk(got, ~b);
    rd(spb_pkg::OFS_DATA_PORT, d);
    chk(d, e);
    rdc(spb_pkg::OFS_FLAGS, 8'ha0);
    wr(spb_pkg::OFS_CONTROL_ONE, 8'h20);
    rdc(spb_pkg::OFS_FLAGS, 8'h20);
    rd(spb_pkg::OFS_IRQ_STATUS, d);
    chk(d & 8'h01, 8'h01);
    chk({7'h00, o_irq}, 8'h00);
    wr(spb_pkg::OFS_IRQ_MASK, 8'h01);
    @(negedge i_clk);
    chk({7'h00, o_irq}, 8'h01);
    wr(spb_pkg::OFS_IRQ_STATUS, 8'h07);
    @(negedge i_clk);
    chk({7'h00, o_irq}, 8'h00);
    for (int k = 0; k < 8; k++) begin
      kk = 3'(k);
      f  = kk[0] & kk[1] & ~kk[2];
      wr(spb_pkg::OFS_CONTROL_TWO, {3'h0, kk[1], 4'h0});
      wr(spb_pkg::OFS_CONTROL_ONE, {3'h6, kk[0], 2'h0, kk[2], 1'b0});
      i_ss_n <= 1'b0;
      repeat (4) @(posedge i_clk);
      rdc(spb_pkg::OFS_FLAGS, {3'h1, f, 4'h0});
      chk({7'h00, o_rx_irq}, {7'h00, f});
      @(posedge i_clk);
      i_ss_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      wr(spb_pkg::OFS_CONTROL_ONE, {3'h6, kk[0], 2'h0, kk[2], 1'b0});
      rdc(spb_pkg::OFS_FLAGS, 8'h20);
    end
    conclude();
  end
endmodule
